/* File: adcl_pkg.sv */
// Package with register map, field layout, reset values and types of the converter control block.
// Operation
// R1 - Channel code bits 4:0, source bit 7
// R2 - Select external: codes 0-7, 21, 22
// R3 - Select internal: temperature sensor, internal reference
// R4 - Scan: four inputs starting at code
// R5 - Unused bits read zero, written zero
// R6 - Change source bit only when stopped
// R7 - Avoid inputs 0/1 with external references
// R8 - Internal source: discard first result
// R9 - Internal source: no one-shot with wait
// R10 - Clear source bit before standby or sleep
// R11 - Eight-bit upper and lower limit registers
// R12 - Compare result, gate done interrupt by mode
// R13 - Compare bits 15:8 or 11:4
// R14 - Write limits only when stopped
// R15 - Upper limit above lower limit
// R16 - Test target: channel, negative, positive reference
// R17 - Use references for zero/full scale
// R18 - Channel write aborts, restarts conversion
// R19 - Out of range: no store, no interrupt
// R20 - Scan results to result registers 0-3
package adcl_pkg;

	localparam int AXI_AW = 14;

	// Register indices; the byte address is four times the index.
	localparam logic [11:0] IDX_CHANNEL  = 12'h001;
	localparam logic [11:0] IDX_UPPER    = 12'h111;
	localparam logic [11:0] IDX_LOWER    = 12'h112;
	localparam logic [11:0] IDX_TEST     = 12'h113;
	localparam logic [11:0] IDX_CONTROL  = 12'h114;
	localparam logic [11:0] IDX_STATUS   = 12'h115;
	localparam logic [11:0] IDX_RESULT0  = 12'h120;

	localparam logic [7:0] CHANNEL_MASK  = 8'h9F;
	localparam logic [7:0] TEST_MASK     = 8'h03;
	localparam logic [7:0] CONTROL_MASK  = 8'h1F;
	localparam int         SRC_BIT       = 7;

	localparam int CTL_RUN   = 0;
	localparam int CTL_POWER = 1;
	localparam int CTL_SCAN  = 2;
	localparam int CTL_RANGE = 3;
	localparam int CTL_RES12 = 4;

	localparam logic [7:0] CHANNEL_RST   = 8'h00;
	localparam logic [7:0] UPPER_RST     = 8'hFF;
	localparam logic [7:0] LOWER_RST     = 8'h00;
	localparam logic [7:0] TEST_RST      = 8'h00;
	localparam logic [7:0] CONTROL_RST   = 8'h00;

	localparam logic [1:0] TGT_CHANNEL   = 2'h0;
	localparam logic [1:0] TGT_NEG_REF   = 2'h2;
	localparam logic [1:0] TGT_POS_REF   = 2'h3;

	localparam logic [4:0] CODE_LAST_PIN = 5'h07;
	localparam logic [4:0] CODE_IN21     = 5'h15;
	localparam logic [4:0] CODE_IN22     = 5'h16;
	localparam logic [4:0] CODE_SCAN_MAX = 5'h04;
	localparam logic [4:0] CODE_TEMP     = 5'h00;
	localparam logic [4:0] CODE_INTREF   = 5'h01;

	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		CV_IDLE,
		CV_START,
		CV_WAIT
	} adcl_conv_e;

endpackage

/* File: adcl_ctrl.sv */
// Converter control block: channel selection, limit compare, test target, AXI4-Lite registers.
//
// The AXI4-Lite register port is this design's own decision.
module adcl_ctrl (
	input  wire logic                         CLK_SYS_IN,
	input  wire logic                         NRST_IN,
	input  wire logic [adcl_pkg::AXI_AW-1:0]  AWADDR_IN,
	input  wire logic                         AWVALID_IN,
	output logic                              AWREADY_OUT,
	input  wire logic [31:0]                  WDATA_IN,
	input  wire logic [3:0]                   WSTRB_IN,
	input  wire logic                         WVALID_IN,
	output logic                              WREADY_OUT,
	output logic [1:0]                        BRESP_OUT,
	output logic                              BVALID_OUT,
	input  wire logic                         BREADY_IN,
	input  wire logic [adcl_pkg::AXI_AW-1:0]  ARADDR_IN,
	input  wire logic                         ARVALID_IN,
	output logic                              ARREADY_OUT,
	output logic [31:0]                       RDATA_OUT,
	output logic [1:0]                        RRESP_OUT,
	output logic                              RVALID_OUT,
	input  wire logic                         RREADY_IN,
	input  wire logic                         RESULT_VALID_IN,
	input  wire logic [15:0]                  RESULT_DATA_IN,
	output logic [4:0]                        MUX_SEL_OUT,
	output logic                              INT_SRC_OUT,
	output logic [1:0]                        TEST_SEL_OUT,
	output logic                              CONV_POWER_OUT,
	output logic                              CONV_START_OUT,
	output logic                              CONV_ABORT_OUT,
	output logic                              DONE_IRQ_OUT
);

	typedef adcl_pkg::adcl_conv_e adcl_conv_t;

	typedef struct packed {
		logic                       awready;
		logic                       wready;
		logic                       aw_held;
		logic                       w_held;
		logic [adcl_pkg::AXI_AW-1:0] waddr;
		logic [7:0]                 wdata;
		logic                       wlane0;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		logic [7:0]                 channel;
		logic [7:0]                 upper;
		logic [7:0]                 lower;
		logic [7:0]                 test;
		logic [7:0]                 control;
		logic [3:0][15:0]           results;
		logic [1:0]                 slot;
		logic                       last_in_range;
		adcl_conv_t                 conv;
		logic [4:0]                 mux_sel;
		logic                       start;
		logic                       abort;
		logic                       irq;
	} adcl_state_s;

	adcl_state_s state_reg;
	adcl_state_s state_next;

	// Analog input number for a scan slot; scan mode walks four inputs upward.
	function automatic logic [4:0] adcl_input(input logic [4:0] code, input logic scan, input logic [1:0] slot);
		adcl_input = scan ? 5'(code + {3'h0, slot}) : code;
	endfunction

	// True when the channel setting is one of the allowed combinations.
	function automatic logic adcl_code_ok(input logic [7:0] chan, input logic scan);
		logic [4:0] code;
		code = chan[4:0];
		if (chan[adcl_pkg::SRC_BIT])
			adcl_code_ok = !scan && (code == adcl_pkg::CODE_TEMP || code == adcl_pkg::CODE_INTREF);
		else if (scan)
			adcl_code_ok = code <= adcl_pkg::CODE_SCAN_MAX;
		else
			adcl_code_ok = code <= adcl_pkg::CODE_LAST_PIN || code == adcl_pkg::CODE_IN21
				|| code == adcl_pkg::CODE_IN22;
	endfunction

	// Register read decode.
	function automatic logic [32:0] adcl_read(input adcl_state_s s, input logic [11:0] idx);
		logic [31:0] d;
		logic        hit;
		d = 32'h0000_0000;
		hit = 1'b1;
		if (idx == adcl_pkg::IDX_CHANNEL)
			d[7:0] = s.channel & adcl_pkg::CHANNEL_MASK; // R5
		else if (idx == adcl_pkg::IDX_UPPER)
			d[7:0] = s.upper; // R11
		else if (idx == adcl_pkg::IDX_LOWER)
			d[7:0] = s.lower; // R11
		else if (idx == adcl_pkg::IDX_TEST)
			d[7:0] = s.test & adcl_pkg::TEST_MASK; // R5
		else if (idx == adcl_pkg::IDX_CONTROL)
			d[7:0] = s.control;
		else if (idx == adcl_pkg::IDX_STATUS)
			d[5:0] = {adcl_code_ok(s.channel, s.control[adcl_pkg::CTL_SCAN]), s.last_in_range,
				s.conv != adcl_pkg::CV_IDLE, 1'b0, s.slot};
		else if (idx[11:2] == adcl_pkg::IDX_RESULT0[11:2])
			d[15:0] = s.results[idx[1:0]]; // R20
		else
			hit = 1'b0;
		adcl_read = {hit, d};
	endfunction

	logic [7:0]  cmp_value;
	logic        in_window;
	logic        pass;
	logic [32:0] rd;
	logic        wr_hit;
	logic [11:0] widx;

	always_comb begin
		state_next = state_reg;
		state_next.start = 1'b0;
		state_next.abort = 1'b0;
		state_next.irq = 1'b0;
		wr_hit = 1'b0;
		widx = state_reg.waddr[13:2];

		// Write channel: address and data taken in either order.
		if (state_reg.bvalid && BREADY_IN)
			state_next.bvalid = 1'b0;
		if (AWVALID_IN && state_reg.awready) begin
			state_next.aw_held = 1'b1;
			state_next.waddr = AWADDR_IN;
		end
		if (WVALID_IN && state_reg.wready) begin
			state_next.w_held = 1'b1;
			state_next.wdata = WDATA_IN[7:0];
			state_next.wlane0 = WSTRB_IN[0];
		end

		// Conversion sequencing toward the converter core.
		unique case (state_reg.conv)
			adcl_pkg::CV_IDLE: begin
				state_next.slot = 2'h0;
				if (state_reg.control[adcl_pkg::CTL_RUN] && state_reg.control[adcl_pkg::CTL_POWER])
					state_next.conv = adcl_pkg::CV_START;
			end
			adcl_pkg::CV_START: begin
				state_next.start = 1'b1;
				state_next.conv = adcl_pkg::CV_WAIT;
			end
			adcl_pkg::CV_WAIT: begin
				if (RESULT_VALID_IN) begin
					if (pass) begin
						state_next.results[state_reg.slot] = RESULT_DATA_IN; // R20 R19
						state_next.irq = 1'b1; // R12 R19
					end
					state_next.last_in_range = pass;
					state_next.slot = state_reg.control[adcl_pkg::CTL_SCAN] ? 2'(state_reg.slot + 2'h1) : 2'h0;
					state_next.conv = adcl_pkg::CV_START;
				end
			end
		endcase
		// A result arriving in the stopping cycle is kept, so no abort goes out beside its done pulse.
		if (!(state_reg.control[adcl_pkg::CTL_RUN] && state_reg.control[adcl_pkg::CTL_POWER])
				&& state_reg.conv != adcl_pkg::CV_IDLE) begin
			state_next.abort = state_reg.conv == adcl_pkg::CV_WAIT && !RESULT_VALID_IN;
			state_next.start = 1'b0;
			state_next.conv = adcl_pkg::CV_IDLE;
			state_next.slot = 2'h0;
		end

		// Register write takes effect once both halves are held.
		if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			wr_hit = widx == adcl_pkg::IDX_CHANNEL || widx == adcl_pkg::IDX_UPPER || widx == adcl_pkg::IDX_LOWER
				|| widx == adcl_pkg::IDX_TEST || widx == adcl_pkg::IDX_CONTROL || widx == adcl_pkg::IDX_STATUS
				|| widx[11:2] == adcl_pkg::IDX_RESULT0[11:2];
			state_next.bresp = wr_hit ? adcl_pkg::RESP_OKAY : adcl_pkg::RESP_SLVERR;
			if (state_reg.wlane0) begin
				if (widx == adcl_pkg::IDX_CHANNEL) begin
					state_next.channel = state_reg.wdata & adcl_pkg::CHANNEL_MASK; // R1 R5
					if (state_reg.conv != adcl_pkg::CV_IDLE && state_reg.control[adcl_pkg::CTL_RUN]
							&& state_reg.control[adcl_pkg::CTL_POWER]) begin
						state_next.abort = state_reg.conv == adcl_pkg::CV_WAIT; // R18
						state_next.start = 1'b0; // R18
						state_next.irq = 1'b0; // R18
						state_next.results = state_reg.results; // R18
						state_next.last_in_range = state_reg.last_in_range;
						state_next.slot = 2'h0; // R18
						state_next.conv = adcl_pkg::CV_START; // R18
					end
				end
				if (widx == adcl_pkg::IDX_UPPER)
					state_next.upper = state_reg.wdata; // R11
				if (widx == adcl_pkg::IDX_LOWER)
					state_next.lower = state_reg.wdata; // R11
				if (widx == adcl_pkg::IDX_TEST)
					state_next.test = state_reg.wdata & adcl_pkg::TEST_MASK; // R5 R16
				if (widx == adcl_pkg::IDX_CONTROL)
					state_next.control = state_reg.wdata & adcl_pkg::CONTROL_MASK;
			end
		end
		state_next.awready = !state_next.aw_held && !state_next.bvalid;
		state_next.wready = !state_next.w_held && !state_next.bvalid;

		// Read channel.
		rd = adcl_read(state_reg, ARADDR_IN[13:2]);
		if (state_reg.rvalid && RREADY_IN)
			state_next.rvalid = 1'b0;
		if (ARVALID_IN && state_reg.arready) begin
			state_next.rvalid = 1'b1;
			state_next.rdata = rd[31:0];
			state_next.rresp = rd[32] ? adcl_pkg::RESP_OKAY : adcl_pkg::RESP_SLVERR;
		end
		state_next.arready = !state_next.rvalid;

		// Input routing follows the slot that the next start will convert.
		state_next.mux_sel = adcl_input(state_next.channel[4:0], state_next.control[adcl_pkg::CTL_SCAN],
			state_next.slot); // R2 R3 R4
	end

	// Limit comparison on the upper eight result bits of the selected resolution.
	always_comb begin
		cmp_value = state_reg.control[adcl_pkg::CTL_RES12] ? RESULT_DATA_IN[11:4] : RESULT_DATA_IN[15:8]; // R13
		in_window = cmp_value >= state_reg.lower && cmp_value <= state_reg.upper; // R12
		pass = state_reg.control[adcl_pkg::CTL_RANGE] ? !in_window : in_window; // R12 R19
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!NRST_IN) begin
			state_reg <= '0;
			state_reg.channel <= adcl_pkg::CHANNEL_RST;
			state_reg.upper <= adcl_pkg::UPPER_RST;
			state_reg.lower <= adcl_pkg::LOWER_RST;
			state_reg.test <= adcl_pkg::TEST_RST;
			state_reg.control <= adcl_pkg::CONTROL_RST;
			state_reg.conv <= adcl_pkg::CV_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign AWREADY_OUT = state_reg.awready;
	assign WREADY_OUT = state_reg.wready;
	assign BVALID_OUT = state_reg.bvalid;
	assign BRESP_OUT = state_reg.bresp;
	assign ARREADY_OUT = state_reg.arready;
	assign RVALID_OUT = state_reg.rvalid;
	assign RDATA_OUT = state_reg.rdata;
	assign RRESP_OUT = state_reg.rresp;
	assign MUX_SEL_OUT = state_reg.mux_sel;
	assign INT_SRC_OUT = state_reg.channel[adcl_pkg::SRC_BIT]; // R1 R3
	assign TEST_SEL_OUT = state_reg.test[1:0]; // R16
	assign CONV_POWER_OUT = state_reg.control[adcl_pkg::CTL_POWER];
	assign CONV_START_OUT = state_reg.start;
	assign CONV_ABORT_OUT = state_reg.abort;
	assign DONE_IRQ_OUT = state_reg.irq;

endmodule // adcl_ctrl

/* File: adcl_ctrl_monitor.sv */
// Concurrent checks on the ports of the converter control block, bound to every instance.
module adcl_ctrl_monitor (
	input wire logic        CLK_SYS_IN,
	input wire logic        NRST_IN,
	input wire logic        BVALID_OUT,
	input wire logic        RVALID_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic        RESULT_VALID_IN,
	input wire logic [4:0]  MUX_SEL_OUT,
	input wire logic        INT_SRC_OUT,
	input wire logic [1:0]  TEST_SEL_OUT,
	input wire logic        CONV_START_OUT,
	input wire logic        CONV_ABORT_OUT,
	input wire logic        DONE_IRQ_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!NRST_IN);
	a_src_by_write: assert property ($changed(INT_SRC_OUT) |-> ##[0:2] BVALID_OUT)
		else $error("source bit moved without a register write");
	a_test_by_write: assert property ($changed(TEST_SEL_OUT) |-> ##[0:2] BVALID_OUT)
		else $error("test target moved without a register write");
	a_mux_by_cause: assert property ($changed(MUX_SEL_OUT) |-> BVALID_OUT || $past(RESULT_VALID_IN))
		else $error("input selection moved without a write or a result");
	a_start_pulse: assert property (CONV_START_OUT |=> !CONV_START_OUT [*2])
		else $error("start pulse too long or too close");
	a_abort_no_start: assert property (CONV_ABORT_OUT |-> !CONV_START_OUT && !DONE_IRQ_OUT)
		else $error("abort together with start or done");
	a_done_cause: assert property (DONE_IRQ_OUT |-> $past(RESULT_VALID_IN))
		else $error("done without a result one cycle before");
	a_done_single: assert property (DONE_IRQ_OUT |=> !DONE_IRQ_OUT)
		else $error("done pulse longer than one cycle");
	a_read_upper: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0000)
		else $error("upper read data bits not zero");
	c_done: cover property (DONE_IRQ_OUT);
	c_abort: cover property (CONV_ABORT_OUT);
	c_scan_end: cover property (CONV_START_OUT && MUX_SEL_OUT == 5'h07);
endmodule // adcl_ctrl_monitor

bind adcl_ctrl adcl_ctrl_monitor i_mon (.CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .BVALID_OUT(BVALID_OUT),
	.RVALID_OUT(RVALID_OUT), .RDATA_OUT(RDATA_OUT), .RESULT_VALID_IN(RESULT_VALID_IN), .MUX_SEL_OUT(MUX_SEL_OUT),
	.INT_SRC_OUT(INT_SRC_OUT), .TEST_SEL_OUT(TEST_SEL_OUT), .CONV_START_OUT(CONV_START_OUT),
	.CONV_ABORT_OUT(CONV_ABORT_OUT), .DONE_IRQ_OUT(DONE_IRQ_OUT));

/* File: adcl_core_model.sv */
// Behavioural converter core: answers each start not cut off by an abort with one result after a fixed latency.
module adcl_core_model #(
	parameter int LAT = 12
) (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        start_in,
	input  wire logic        abort_in,
	input  wire logic [15:0] sample_in,
	output logic             valid_out,
	output logic [15:0]      data_out
);
	int cnt;
	always @(posedge clk_in) begin
		if (!nrst_in || abort_in) begin
			cnt <= 0;
		end else if (start_in) begin
			cnt <= LAT;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		valid_out <= nrst_in && !abort_in && cnt == 1;
		// Data is only meaningful with the strobe; otherwise it shows the inverse of the last value, or zero during reset.
		data_out <= (nrst_in && !abort_in && cnt == 1) ? sample_in : (nrst_in ? ~data_out : 16'h0000);
	end
endmodule // adcl_core_model

/* File: adcl_tb.sv */
// Self-checking testbench of the converter control block.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0, nrst = 1'b0;
	logic [13:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = '0;
	// Response ready lines stay high, so back-to-back calls never toggle them within one time step.
	logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1, seen;
	logic        awready, wready, bvalid, arready, rvalid, res_v, src, pwr, start, abort, done;
	logic [1:0]  bresp, rresp, tsel;
	logic [15:0] res_d, smp = '0;
	logic [4:0]  mux, starts[$];
	logic [7:0]  codes[3] = '{8'h15, 8'h16, 8'h07};
	logic [1:0]  tgts[3] = '{adcl_pkg::TGT_NEG_REF, adcl_pkg::TGT_POS_REF, adcl_pkg::TGT_CHANNEL};
	int          error_cnt = 0, checks_done = 0, cyc = 0, aborts = 0;

	always #5 clk = ~clk;
	adcl_ctrl i_dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
		.WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
		.BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
		.RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .RESULT_VALID_IN(res_v),
		.RESULT_DATA_IN(res_d), .MUX_SEL_OUT(mux), .INT_SRC_OUT(src), .TEST_SEL_OUT(tsel), .CONV_POWER_OUT(pwr),
		.CONV_START_OUT(start), .CONV_ABORT_OUT(abort), .DONE_IRQ_OUT(done));
	adcl_core_model i_core (.clk_in(clk), .nrst_in(nrst), .start_in(start), .abort_in(abort),
		.sample_in(smp ^ {3'h0, mux, 8'h00}), .valid_out(res_v), .data_out(res_d));

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (abort) aborts <= aborts + 1;
		if (cyc == 10000) begin
			error_cnt++;
			summarize();
		end
	end

	// Start pulses are logged at the falling edge, away from the edges at which tests resume.
	always @(negedge clk) begin
		if (start) starts.push_back(mux);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er = adcl_pkg::RESP_OKAY);
		logic a_t, w_t, b_t;
		logic [1:0] r;
		int n;
		n = 0;
		b_t = 0;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!b_t && n < 50) begin
			@(negedge clk);
			a_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			r = bresp;
			@(posedge clk);
			if (a_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			n++;
		end
		chk({30'h0, r}, {30'h0, er}, "write response");
	endtask

	task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] er = adcl_pkg::RESP_OKAY);
		logic a_t, v;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		v = 0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		while (!v && n < 50) begin
			@(negedge clk);
			a_t = arvalid && arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (a_t) arvalid <= 1'b0;
			n++;
		end
		chk(d, exp, "read data");
		chk({30'h0, r}, {30'h0, er}, "read response");
	endtask

	// Waits a bounded time for a done pulse or, with want_done low, for a start pulse.
	task automatic wait_ev(input logic want_done, output logic hit);
		hit = 0;
		for (int n = 0; n < 40 && !hit; n++) begin
			@(negedge clk);
			hit = want_done ? done : start;
		end
		@(posedge clk);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(adcl_pkg::IDX_UPPER, 32'hFF);
		rd(adcl_pkg::IDX_LOWER, 32'h00);
		rd(adcl_pkg::IDX_TEST, 32'h00);
		wr(adcl_pkg::IDX_CHANNEL, 8'hFF);
		rd(adcl_pkg::IDX_CHANNEL, 32'h9F);
		chk({31'h0, src}, 32'h1, "source bit");
		wr(adcl_pkg::IDX_CHANNEL, 8'h00);
		wr(adcl_pkg::IDX_TEST, 8'hFF);
		rd(adcl_pkg::IDX_TEST, 32'h03);
		foreach (tgts[i]) begin
			wr(adcl_pkg::IDX_TEST, {6'h0, tgts[i]});
			chk({30'h0, tsel}, {30'h0, tgts[i]}, "test target");
		end
		wr(12'h050, 8'h11, adcl_pkg::RESP_SLVERR);
		rd(12'h050, 32'h0, adcl_pkg::RESP_SLVERR);
		wr(adcl_pkg::IDX_UPPER, 8'h80);
		wr(adcl_pkg::IDX_LOWER, 8'h40);
		smp <= 16'h5000;
		wr(adcl_pkg::IDX_CONTROL, 8'h03);
		wait_ev(1'b1, seen);
		chk({31'h0, seen}, 32'h1, "done inside range");
		wr(adcl_pkg::IDX_CONTROL, 8'h00);
		smp <= 16'h9000;
		wr(adcl_pkg::IDX_CONTROL, 8'h03);
		wait_ev(1'b1, seen);
		chk({31'h0, seen}, 32'h0, "done outside range");
		wr(adcl_pkg::IDX_CONTROL, 8'h00);
		rd(adcl_pkg::IDX_RESULT0, 32'h5000);
		wr(adcl_pkg::IDX_CONTROL, 8'h0B);
		wait_ev(1'b1, seen);
		chk({31'h0, seen}, 32'h1, "done in outer range");
		wr(adcl_pkg::IDX_CONTROL, 8'h00);
		rd(adcl_pkg::IDX_RESULT0, 32'h9000);
		smp <= 16'h0500;
		wr(adcl_pkg::IDX_CONTROL, 8'h13);
		wait_ev(1'b1, seen);
		chk({31'h0, seen}, 32'h1, "twelve bit compare");
		wr(adcl_pkg::IDX_CONTROL, 8'h00);
		smp <= 16'h5000;
		wr(adcl_pkg::IDX_CHANNEL, 8'h04);
		starts.delete();
		wr(adcl_pkg::IDX_CONTROL, 8'h07);
		repeat (4) wait_ev(1'b1, seen);
		wr(adcl_pkg::IDX_CONTROL, 8'h00);
		for (int k = 0; k < 4; k++) begin
			chk({27'h0, starts[k]}, 32'(4 + k), "scan input");
			rd(adcl_pkg::IDX_RESULT0 + 12'(k), 32'h5000 ^ 32'((4 + k) << 8));
		end
		wr(adcl_pkg::IDX_CHANNEL, 8'h81);
		wr(adcl_pkg::IDX_CONTROL, 8'h03);
		repeat (2) wait_ev(1'b1, seen);
		chk({26'h0, src, mux}, {26'h0, 1'b1, adcl_pkg::CODE_INTREF}, "internal reference input");
		rd(adcl_pkg::IDX_RESULT0, 32'h5100);
		wr(adcl_pkg::IDX_CONTROL, 8'h00);
		wr(adcl_pkg::IDX_CHANNEL, 8'h00);
		wr(adcl_pkg::IDX_CONTROL, 8'h03);
		foreach (codes[i]) begin
			wait_ev(1'b0, seen);
			wr(adcl_pkg::IDX_CHANNEL, codes[i]);
			wait_ev(1'b0, seen);
			chk({27'h0, starts[$]}, {24'h0, codes[i]}, "input after rewrite");
		end
		wr(adcl_pkg::IDX_CONTROL, 8'h00);
		chk({31'h0, aborts != 0}, 32'h1, "abort pulse");
		summarize();
	end
endmodule // tb
